// >>> src/i2cee_pkg.sv
// Purpose: constants and types of the two-wire serial memory slave
// Assumes: 100 MHz system clock, 1024 x 8 array, 16-byte page
// Notes: imported by nobody; every use is scoped
package i2cee_pkg;

  // ****************************************
  // Array geometry
  // ****************************************
  localparam int ADDR_W = 10;
  localparam int MEM_DEPTH = 1024;
  localparam int PAGE_W = 4;
  localparam int PAGE_LEN = 16;
  localparam logic [7:0] ERASED = 8'hFF;
  localparam logic [ADDR_W-1:0] ADDR_ONE = 10'h001;
  localparam logic [PAGE_W-1:0] NIB_ONE = 4'h1;

  // ****************************************
  // Bus framing
  // ****************************************
  localparam logic [3:0] DEV_TYPE = 4'hA;
  localparam logic [3:0] BIT_ONE = 4'h1;
  localparam logic [3:0] BIT_LAST = 4'h8;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_MHZ = 100;
  localparam int TWR_MS = 5;
  localparam int TWR_CYC_DEF = TWR_MS * 1000 * CLK_MHZ;
  localparam int TMR_W = 19;
  localparam logic [TMR_W-1:0] TMR_ONE = 19'h00001;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [8:0] {
    ST_IDLE = 9'h001,
    ST_DEVADR = 9'h002,
    ST_DEVACK = 9'h004,
    ST_MADR = 9'h008,
    ST_MACK = 9'h010,
    ST_WDAT = 9'h020,
    ST_WACK = 9'h040,
    ST_SEND = 9'h080,
    ST_RACK = 9'h100
  } i2cee_st_t;

  typedef struct packed {
    i2cee_st_t st;
    logic scl_m;
    logic scl_s;
    logic scl_p;
    logic sda_m;
    logic sda_s;
    logic sda_p;
    logic wp_m;
    logic wp_s;
    logic [3:0] bitcnt;
    logic [7:0] shreg;
    logic [ADDR_W-1:0] addr;
    logic rw;
    logic wp_lat;
    logic mack;
    logic sda_oe;
    logic [PAGE_LEN-1:0] pvalid;
    logic busy;
    logic [TMR_W-1:0] tmr;
    logic [PAGE_W-1:0] cidx;
  } i2cee_state_t;

endpackage

// >>> src/i2cee_slave.sv
// Purpose: protocol engine of a two-wire serial memory slave
// Assumes: scl, sda and wp are asynchronous pins, sampled twice
// Notes: internal write cycle counted in system clocks
// Contract
// R1 - Data edge while clock high: start/stop
// R2 - Ignore traffic until start; stop ends command
// R3 - Respond only to type code 1010
// R4 - Next address bits give upper memory address
// R5 - Last address bit: 1 read, 0 write
// R6 - Ninth clock: transmitter releases, receiver acknowledges
// R7 - Byte write: acknowledge every master byte
// R8 - Stop starts write cycle; busy means silent
// R9 - Buffer up to sixteen page bytes
// R10 - Page latched, low nibble wraps within page
// R11 - Commit whole page in one cycle
// R12 - Poll: nack while busy, ack after
// R13 - Sample protect on fall before data
// R14 - Protected: nack data, discard the write
// R15 - Array starts erased to all ones
// R16 - Address-less read returns current address byte
// R17 - Nack then stop returns to idle
// R18 - Dummy write loads address for read
// R19 - Keep sending while master acknowledges
// R20 - Read address wraps over whole array
// R21 - Sample on rise, change on fall, pull-low
// R22 - Data stable while clock high
// R23 - Undriven protect pin reads low; no pull-down in this logic, wp_in is sampled as driven
// R24 - Bytes travel most significant bit first
// R25 - Address ends one past last access
// R26 - Upper bits match array size
`timescale 1ns/1ps
module i2cee_slave #(
  parameter int TWR_CYC = i2cee_pkg::TWR_CYC_DEF
) (
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  input wire logic wp_in,
  output logic busy_out
);

  localparam logic [i2cee_pkg::TMR_W-1:0] TWR_LD =
    TWR_CYC[i2cee_pkg::TMR_W-1:0];
  localparam int AW = i2cee_pkg::ADDR_W;
  localparam int PW = i2cee_pkg::PAGE_W;

  // ****************************************
  // State and memories
  // ****************************************
  i2cee_pkg::i2cee_state_t s;
  i2cee_pkg::i2cee_state_t n;
  // Erased array at power up; one clocked writer only
  logic [7:0] mem [i2cee_pkg::MEM_DEPTH] =
    '{default: i2cee_pkg::ERASED}; // R15
  logic [7:0] pbuf [i2cee_pkg::PAGE_LEN];
  logic start;
  logic stop;
  logic rise;
  logic fall;
  logic pb_we;
  logic [7:0] rd_byte;

  // ****************************************
  // Bus conditions
  // ****************************************
  // Only settled samples feed edge logic
  assign rise = s.scl_s && !s.scl_p;
  assign fall = !s.scl_s && s.scl_p;
  // Data moving under a high clock
  assign start = s.scl_s && s.scl_p && !s.sda_s && s.sda_p; // R1
  assign stop = s.scl_s && s.scl_p && s.sda_s && !s.sda_p; // R1
  assign rd_byte = mem[s.addr];

  // Open drain: only ever pulls low
  assign sda_out = 1'b0; // R21
  assign sda_oe_out = s.sda_oe;
  assign busy_out = s.busy;

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    n = s;
    pb_we = 1'b0;
    n.scl_m = scl_in;
    n.scl_s = s.scl_m;
    n.scl_p = s.scl_s;
    n.sda_m = sda_in;
    n.sda_s = s.sda_m;
    n.sda_p = s.sda_s;
    // No pull-down in this logic; an open input is sampled as is
    n.wp_m = wp_in; // R23
    n.wp_s = s.wp_m;
    // Commit walks the page repeatedly; rewrites are harmless
    n.cidx = s.busy ? s.cidx + i2cee_pkg::NIB_ONE : '0; // R11
    if (s.busy) begin
      n.tmr = s.tmr - i2cee_pkg::TMR_ONE;
      if (s.tmr == i2cee_pkg::TMR_ONE) begin
        n.busy = 1'b0;
        n.pvalid = '0;
      end
    end
    if (start) begin
      n.st = i2cee_pkg::ST_DEVADR; // R2
      n.bitcnt = '0;
      n.sda_oe = 1'b0;
      if (!s.busy) begin
        n.pvalid = '0;
      end
    end else if (stop) begin
      n.st = i2cee_pkg::ST_IDLE; // R2 R17
      n.sda_oe = 1'b0;
      if (!s.busy && |s.pvalid) begin
        n.busy = 1'b1; // R8 R11
        n.tmr = TWR_LD;
      end
    end else if (rise) begin
      case (s.st)
        i2cee_pkg::ST_DEVADR,
        i2cee_pkg::ST_MADR,
        i2cee_pkg::ST_WDAT: begin
          n.shreg = {s.shreg[6:0], s.sda_s}; // R21 R24
          n.bitcnt = s.bitcnt + i2cee_pkg::BIT_ONE;
        end
        i2cee_pkg::ST_RACK: begin
          n.mack = !s.sda_s; // R6
        end
        default: begin
        end
      endcase
    end else if (fall) begin
      case (s.st)
        i2cee_pkg::ST_DEVADR: begin
          if (s.bitcnt == i2cee_pkg::BIT_LAST) begin
            // Busy array stays silent to polling
            if (s.shreg[7:4] == i2cee_pkg::DEV_TYPE && !s.busy) begin
              n.st = i2cee_pkg::ST_DEVACK; // R3 R12
              n.sda_oe = 1'b1;
              n.rw = s.shreg[0]; // R5
              // Bit 3 unused on this capacity
              n.addr[AW-1:8] = s.shreg[AW-8:1]; // R4 R26
            end else begin
              n.st = i2cee_pkg::ST_IDLE; // R8 R12
            end
          end
        end
        i2cee_pkg::ST_DEVACK: begin
          n.bitcnt = '0;
          n.sda_oe = 1'b0; // R6
          if (s.rw) begin
            n.st = i2cee_pkg::ST_SEND; // R16 R18
            n.shreg = rd_byte;
            n.sda_oe = !rd_byte[7]; // R24
            n.bitcnt = i2cee_pkg::BIT_ONE;
            n.addr = s.addr + i2cee_pkg::ADDR_ONE; // R25
          end else begin
            n.st = i2cee_pkg::ST_MADR;
          end
        end
        i2cee_pkg::ST_MADR: begin
          if (s.bitcnt == i2cee_pkg::BIT_LAST) begin
            n.addr[7:0] = s.shreg; // R18
            n.st = i2cee_pkg::ST_MACK;
            n.sda_oe = 1'b1; // R7
          end
        end
        i2cee_pkg::ST_MACK: begin
          n.sda_oe = 1'b0;
          n.bitcnt = '0;
          n.st = i2cee_pkg::ST_WDAT;
          n.wp_lat = s.wp_s; // R13
        end
        i2cee_pkg::ST_WDAT: begin
          if (s.bitcnt == i2cee_pkg::BIT_LAST) begin
            if (s.wp_lat) begin
              // Line left released: no acknowledge
              n.st = i2cee_pkg::ST_IDLE; // R14
            end else begin
              pb_we = 1'b1; // R9
              n.pvalid[s.addr[PW-1:0]] = 1'b1;
              // Page part held, low nibble wraps
              n.addr[PW-1:0] = s.addr[PW-1:0] + i2cee_pkg::NIB_ONE; // R10
              n.st = i2cee_pkg::ST_WACK;
              n.sda_oe = 1'b1; // R7
            end
          end
        end
        i2cee_pkg::ST_WACK: begin
          n.sda_oe = 1'b0;
          n.bitcnt = '0;
          n.st = i2cee_pkg::ST_WDAT;
        end
        i2cee_pkg::ST_SEND: begin
          if (s.bitcnt == i2cee_pkg::BIT_LAST) begin
            n.sda_oe = 1'b0; // R6
            n.st = i2cee_pkg::ST_RACK;
          end else begin
            n.sda_oe = !s.shreg[6]; // R21 R22 R24
            n.shreg = {s.shreg[6:0], 1'b0};
            n.bitcnt = s.bitcnt + i2cee_pkg::BIT_ONE;
          end
        end
        i2cee_pkg::ST_RACK: begin
          if (s.mack) begin
            n.st = i2cee_pkg::ST_SEND; // R19
            n.shreg = rd_byte;
            n.sda_oe = !rd_byte[7];
            n.bitcnt = i2cee_pkg::BIT_ONE;
            // Natural wrap over the whole array
            n.addr = s.addr + i2cee_pkg::ADDR_ONE; // R20 R25
          end else begin
            n.st = i2cee_pkg::ST_IDLE; // R17
          end
        end
        default: begin
        end
      endcase
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      s <= '0;
      s.st <= i2cee_pkg::ST_IDLE;
      s.scl_m <= 1'b1;
      s.scl_s <= 1'b1;
      s.scl_p <= 1'b1;
      s.sda_m <= 1'b1;
      s.sda_s <= 1'b1;
      s.sda_p <= 1'b1;
    end else begin
      s <= n;
    end
  end

  // Page buffer and array hold no reset
  always_ff @(posedge sys_clk_in) begin
    if (pb_we) begin
      pbuf[s.addr[PW-1:0]] <= s.shreg; // R9
    end
    if (s.busy && s.pvalid[s.cidx]) begin
      mem[{s.addr[AW-1:PW], s.cidx}] <= pbuf[s.cidx]; // R11
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!reset_n_in);

  sequence dev_byte_s;
    fall && s.st == i2cee_pkg::ST_DEVADR &&
      s.bitcnt == i2cee_pkg::BIT_LAST;
  endsequence

  sequence rd_byte_end_s;
    fall && s.st == i2cee_pkg::ST_SEND &&
      s.bitcnt == i2cee_pkg::BIT_LAST;
  endsequence

  sequence wr_byte_s;
    fall && s.st == i2cee_pkg::ST_WDAT &&
      s.bitcnt == i2cee_pkg::BIT_LAST;
  endsequence

  start_enter_a: assert property ( // R1
    start |=> s.st == i2cee_pkg::ST_DEVADR && !s.sda_oe)
    else $error("start did not open address phase");

  stop_idle_a: assert property ( // R2
    stop |=> s.st == i2cee_pkg::ST_IDLE ##1 !s.sda_oe)
    else $error("stop did not end the command");

  type_match_a: assert property ( // R3
    dev_byte_s and s.shreg[7:4] != i2cee_pkg::DEV_TYPE |=>
      s.st == i2cee_pkg::ST_IDLE && !s.sda_oe)
    else $error("foreign address answered");

  busy_poll_a: assert property ( // R12
    dev_byte_s and s.busy |=> !s.sda_oe [*3])
    else $error("busy array acknowledged");

  rd_release_a: assert property ( // R6
    rd_byte_end_s |=> !s.sda_oe && s.st == i2cee_pkg::ST_RACK)
    else $error("line held on ninth clock");

  wp_reject_a: assert property ( // R14
    wr_byte_s and s.wp_lat |=>
      !s.sda_oe && s.pvalid == $past(s.pvalid))
    else $error("protected byte accepted");

  page_hold_a: assert property ( // R10
    wr_byte_s and !s.wp_lat |=>
      s.addr[AW-1:PW] == $past(s.addr[AW-1:PW]) && s.sda_oe)
    else $error("page address moved");

  stop_commit_a: assert property ( // R8
    stop && !s.busy && |s.pvalid |=> s.busy && s.tmr == TWR_LD)
    else $error("stop did not start write cycle");

  commit_end_a: assert property ( // R11
    s.busy && s.tmr == i2cee_pkg::TMR_ONE |=>
      !s.busy && s.pvalid == '0)
    else $error("write cycle did not finish");

  seq_inc_a: assert property ( // R19
    fall && s.st == i2cee_pkg::ST_RACK && s.mack |=>
      s.addr == $past(s.addr) + i2cee_pkg::ADDR_ONE)
    else $error("read address did not advance");

endmodule

// >>> test/i2cee_master.sv
// Purpose: two-wire bus master model facing the memory slave
// Assumes: SCL period 8 sys clocks, low 6, high 2
// Notes: tasks are entered just after a rising sys clock edge
`timescale 1ns/1ps
module i2cee_master (
  input wire logic sys_clk_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_out
);
  initial begin
    scl_out = 1'b1;
    sda_out = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_in);
  endtask
  // Long low phase leaves room for the slave's sync delay
  task automatic bit_x(input logic b, output logic r);
    scl_out <= 1'b0;
    tick(3);
    sda_out <= b;
    tick(3);
    scl_out <= 1'b1;
    tick(1);
    r = sda_in;
    tick(1);
  endtask
  task automatic start_c();
    scl_out <= 1'b0;
    tick(3);
    sda_out <= 1'b1;
    tick(3);
    scl_out <= 1'b1;
    tick(4);
    sda_out <= 1'b0;
    tick(4);
  endtask
  // Clock stands still high after this
  task automatic stop_c();
    scl_out <= 1'b0;
    tick(3);
    sda_out <= 1'b0;
    tick(3);
    scl_out <= 1'b1;
    tick(4);
    sda_out <= 1'b1;
    tick(4);
  endtask
  task automatic send_byte(input logic [7:0] d, output logic nack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(d[i], r);
    bit_x(1'b1, nack);
  endtask
  task automatic get_byte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(1'b1, d[i]);
    bit_x(last, r);
  endtask
endmodule

// >>> test/i2cee_slave_tb.sv
// Purpose: self-checking bench of the serial memory slave
// Assumes: write cycle shortened to 200 clocks
// Notes: memory model in the bench gives every expected byte
`timescale 1ns/1ps
module i2cee_slave_tb;
  localparam int TWR = 200;
  logic sys_clk_in, reset_n_in, wp_in, scl, m_sda;
  logic sda_out, sda_oe_out, busy_out, nk;
  wire logic sda_w;
  logic [7:0] mem [1024];
  logic [9:0] pa;
  logic [31:0] rnd;
  integer seed = 25;
  int err_count = 0;
  int checked = 0;
  // Pull-up wins unless a party pulls low
  assign sda_w = m_sda & (sda_oe_out ? sda_out : 1'b1);
  i2cee_slave #(.TWR_CYC(TWR)) i_i2cee_slave (.sys_clk_in(sys_clk_in),
    .reset_n_in(reset_n_in), .scl_in(scl), .sda_in(sda_w),
    .sda_out(sda_out), .sda_oe_out(sda_oe_out), .wp_in(wp_in),
    .busy_out(busy_out));
  i2cee_master i_i2cee_master (.sys_clk_in(sys_clk_in), .sda_in(sda_w),
    .scl_out(scl), .sda_out(m_sda));
  task automatic cmp1(input string n, input logic e, input logic g);
    checked++;
    if (g !== e) begin
      $display("unexpected %s exp %h got %h", n, e, g);
      err_count++;
    end
  endtask
  task automatic cmp8(input string n, input logic [7:0] e,
    input logic [7:0] g);
    checked++;
    if (g !== e) begin
      $display("unexpected %s exp %h got %h", n, e, g);
      err_count++;
    end
  endtask
  task automatic report_and_stop();
    $display("mismatches %0d checks %0d", err_count, checked);
    if (err_count == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  function automatic logic [7:0] sb(input logic [9:0] a, input logic rw);
    return {i2cee_pkg::DEV_TYPE, 1'b0, a[9:8], rw};
  endfunction
  // Sampled mid-cycle so the edge's updates have landed
  task automatic chk_idle(input logic eb);
    @(negedge sys_clk_in);
    cmp1("busy", eb, busy_out);
    cmp1("sda_oe", 1'b0, sda_oe_out);
    @(posedge sys_clk_in);
  endtask
  task automatic set_addr(input logic [9:0] a);
    logic k;
    i_i2cee_master.start_c();
    i_i2cee_master.send_byte(sb(a, 1'b0), k);
    cmp1("dev_ack", 1'b0, k);
    i_i2cee_master.send_byte(a[7:0], k);
    cmp1("adr_ack", 1'b0, k);
  endtask
  task automatic wr_seq(input logic [9:0] a, input int n, input logic p);
    logic k;
    logic [7:0] d;
    wp_in <= p;
    set_addr(a);
    for (int j = 0; j < n; j++) begin
      rnd = $random(seed);
      d = rnd[7:0];
      i_i2cee_master.send_byte(d, k);
      cmp1("data_ack", p, k);
      if (!p) mem[{a[9:4], a[3:0] + 4'(j)}] = d;
    end
    i_i2cee_master.stop_c();
    wp_in <= 1'b0;
    chk_idle(!p);
    if (!p) begin
      i_i2cee_master.start_c();
      i_i2cee_master.send_byte(sb(a, 1'b0), k);
      cmp1("poll_busy", 1'b1, k);
      i_i2cee_master.stop_c();
      for (int i = 0; i < TWR && busy_out === 1'b1; i++)
        @(posedge sys_clk_in);
      chk_idle(1'b0);
      i_i2cee_master.start_c();
      i_i2cee_master.send_byte(sb(a, 1'b0), k);
      cmp1("poll_done", 1'b0, k);
      i_i2cee_master.stop_c();
    end
  endtask
  task automatic rd_seq(input logic [9:0] a, input int n, input logic s);
    logic k;
    logic [7:0] d;
    if (s) set_addr(a);
    i_i2cee_master.start_c();
    i_i2cee_master.send_byte(sb(a, 1'b1), k);
    cmp1("rd_ack", 1'b0, k);
    for (int j = 0; j < n; j++) begin
      i_i2cee_master.get_byte(j == n - 1, d);
      cmp8("rd_data", mem[a + 10'(j)], d);
    end
    i_i2cee_master.stop_c();
    chk_idle(1'b0);
  endtask
  initial begin
    sys_clk_in = 1'b0;
    forever #5 sys_clk_in = ~sys_clk_in;
  end
  initial begin
    repeat (60000) @(posedge sys_clk_in);
    err_count++;
    report_and_stop();
  end
  initial begin
    reset_n_in = 1'b0;
    wp_in = 1'b0;
    for (int i = 0; i < 1024; i++) mem[i] = 8'hFF;
    repeat (3) @(posedge sys_clk_in);
    reset_n_in <= 1'b1;
    repeat (4) @(posedge sys_clk_in);
    chk_idle(1'b0);
    rnd = $random(seed);
    pa = rnd[9:0];
    rd_seq(pa, 2, 1'b1);
    wr_seq(pa, 18, 1'b0);
    rd_seq({pa[9:4], 4'h0}, 16, 1'b1);
    rd_seq({pa[9:4], 4'h0} + 10'h010, 1, 1'b0);
    wr_seq(pa ^ 10'h155, 3, 1'b1);
    rd_seq(pa ^ 10'h155, 3, 1'b1);
    wr_seq(10'h3FF, 1, 1'b0);
    rd_seq(10'h3FE, 3, 1'b1);
    i_i2cee_master.start_c();
    i_i2cee_master.send_byte(8'hB0, nk);
    cmp1("bad_type", 1'b1, nk);
    i_i2cee_master.stop_c();
    i_i2cee_master.start_c();
    i_i2cee_master.send_byte(8'hA8, nk);
    cmp1("spare_bit", 1'b0, nk);
    i_i2cee_master.stop_c();
    report_and_stop();
  end
endmodule
